/* File: verilog/tcpwm_top.sv */
// Purpose: 16-bit down counting timer/counter/pwm with ahb-lite registers
// Assumes: reset, capture, enable and kill inputs come from outside hclk
// Notes:   all outputs registered
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "tcpwm_map.svh"
module tcpwm_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        tmr_reset_in,
   input  wire logic        capture_in,
   input  wire logic        enable_in,
   input  wire logic        kill_in,
   input  wire logic        ext_clk_in,
   output logic             cmp_out,
   output logic             tc_out,
   output logic             pwm_true_out,
   output logic             pwm_comp_out,
   output logic             irq
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic       ext_prev_reg;
   logic       cap_prev_reg;
   logic       rst_prev_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else begin
         sync1_reg <= {ext_clk_in, kill_in, enable_in, capture_in, tmr_reset_in};
         sync2_reg <= sync1_reg;
      end
   end

   wire rst_s = sync2_reg[0];
   wire cap_s = sync2_reg[1];
   wire en_s  = sync2_reg[2];
   wire kill_s = sync2_reg[3];
   wire ext_s = sync2_reg[4];

   // edge detectors read only the second stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_prev_reg <= 1'b0;
         cap_prev_reg <= 1'b0;
         rst_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_s;
         cap_prev_reg <= cap_s;
         rst_prev_reg <= rst_s;
      end
   end

   wire cap_evt = cap_s & ~cap_prev_reg;
   wire rst_evt = rst_s & ~rst_prev_reg;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0]  ctrl_reg;
   logic [15:0] period_reg;
   logic [15:0] cmpval_reg;
   logic [15:0] count_reg;
   logic [15:0] capt_reg;
   logic [7:0]  dead_reg;
   logic [2:0]  stat_reg;
   logic [2:0]  mask_reg;
   logic [15:0] clkdiv_reg;
   logic [15:0] div_cnt_reg;
   tcpwm_pkg::tcpwm_state_t state_reg;

   // ahb address phase capture
   logic       wr_pend_reg;
   logic [7:0] addr_reg;
   wire        ahb_go = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= ahb_go & hwrite;
         addr_reg    <= haddr[7:0];
      end
   end

   wire wr_ctrl   = wr_pend_reg && addr_reg == `TCPWM_OFS_CTRL;
   wire wr_period = wr_pend_reg && addr_reg == `TCPWM_OFS_PERIOD;
   wire wr_stat   = wr_pend_reg && addr_reg == `TCPWM_OFS_STAT;

   // writable configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg   <= `TCPWM_RST_CTRL;
         period_reg <= `TCPWM_RST_PERIOD;
         cmpval_reg <= `TCPWM_RST_CMP;
         dead_reg   <= `TCPWM_RST_DEAD;
         mask_reg   <= 3'h0;
         clkdiv_reg <= `TCPWM_RST_CLKDIV;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            `TCPWM_OFS_CTRL:   ctrl_reg   <= hwdata[7:0];
            `TCPWM_OFS_PERIOD: period_reg <= hwdata[15:0];
            `TCPWM_OFS_CMP:    cmpval_reg <= hwdata[15:0];
            `TCPWM_OFS_DEAD:   dead_reg   <= hwdata[7:0];
            `TCPWM_OFS_MASK:   mask_reg   <= hwdata[2:0];
            `TCPWM_OFS_CLKDIV: clkdiv_reg <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // read data: live count read is side-effect free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (ahb_go && !hwrite) begin
         case (haddr[7:0])
            `TCPWM_OFS_CTRL:   hrdata <= {24'h000000, ctrl_reg};
            `TCPWM_OFS_PERIOD: hrdata <= {16'h0000, period_reg};
            `TCPWM_OFS_CMP:    hrdata <= {16'h0000, cmpval_reg};
            `TCPWM_OFS_COUNT:  hrdata <= {16'h0000, count_reg};
            `TCPWM_OFS_CAPT:   hrdata <= {16'h0000, capt_reg};
            `TCPWM_OFS_DEAD:   hrdata <= {24'h000000, dead_reg};
            `TCPWM_OFS_STAT:   hrdata <= {29'h0, stat_reg};
            `TCPWM_OFS_MASK:   hrdata <= {29'h0, mask_reg};
            `TCPWM_OFS_CLKDIV: hrdata <= {16'h0000, clkdiv_reg};
            default:           hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // zero wait state, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------
   // clock selection: divider enable or external edge
   // ----------------------------------------
   wire div_tick = (div_cnt_reg == clkdiv_reg);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_reg <= 16'h0000;
      end else if (div_tick) begin
         div_cnt_reg <= 16'h0000;
      end else begin
         div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
   end

   wire ext_tick = ext_s & ~ext_prev_reg;
   wire tick = ctrl_reg[`TCPWM_CTRL_CLKSEL] ? ext_tick : div_tick;

   // ----------------------------------------
   // counter state machine
   // ----------------------------------------
   tcpwm_pkg::tcpwm_mode_t mode;
   assign mode = tcpwm_pkg::tcpwm_mode_t'(ctrl_reg[`TCPWM_CTRL_MODE_HI:`TCPWM_CTRL_MODE_LO]);
   wire run_bit  = ctrl_reg[`TCPWM_CTRL_RUN];
   wire start    = wr_ctrl & hwdata[`TCPWM_CTRL_RUN] & ~run_bit;
   wire gate_ok  = (mode != tcpwm_pkg::TCPWM_GATED) | en_s;
   wire step     = (state_reg == tcpwm_pkg::TCPWM_ST_RUN) & tick & gate_ok;
   wire at_zero  = (count_reg == 16'h0000);
   wire tc_evt   = step & at_zero;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= tcpwm_pkg::TCPWM_ST_IDLE;
         count_reg <= `TCPWM_RST_PERIOD;
      end else begin
         case (state_reg)
            tcpwm_pkg::TCPWM_ST_IDLE: begin
               if (start) begin
                  count_reg <= period_reg;
                  state_reg <= tcpwm_pkg::TCPWM_ST_RUN;
               end
            end
            tcpwm_pkg::TCPWM_ST_RUN: begin
               if (!run_bit) begin
                  state_reg <= tcpwm_pkg::TCPWM_ST_IDLE;
               end else if (rst_evt) begin
                  count_reg <= period_reg;
               end else if (tc_evt) begin
                  count_reg <= period_reg;
                  if (mode == tcpwm_pkg::TCPWM_ONCE) begin
                     state_reg <= tcpwm_pkg::TCPWM_ST_DONE;
                  end
               end else if (step) begin
                  count_reg <= count_reg - 16'h0001;
               end
            end
            tcpwm_pkg::TCPWM_ST_DONE: begin
               if (!run_bit) begin
                  state_reg <= tcpwm_pkg::TCPWM_ST_IDLE;
               end else if (rst_evt) begin
                  count_reg <= period_reg;
                  state_reg <= tcpwm_pkg::TCPWM_ST_RUN;
               end
            end
            default: state_reg <= tcpwm_pkg::TCPWM_ST_IDLE;
         endcase
      end
   end

   // capture holding register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capt_reg <= 16'h0000;
      end else if (cap_evt) begin
         capt_reg <= count_reg;
      end
   end

   // ----------------------------------------
   // comparator
   // ----------------------------------------
   logic cmp_true;
   always_comb begin
      case (tcpwm_pkg::tcpwm_cmp_t'(ctrl_reg[`TCPWM_CTRL_CMP_HI:`TCPWM_CTRL_CMP_LO]))
         tcpwm_pkg::TCPWM_CMP_LESS: cmp_true = count_reg <  cmpval_reg;
         tcpwm_pkg::TCPWM_CMP_LE:   cmp_true = count_reg <= cmpval_reg;
         tcpwm_pkg::TCPWM_CMP_EQ:   cmp_true = count_reg == cmpval_reg;
         tcpwm_pkg::TCPWM_CMP_GE:   cmp_true = count_reg >= cmpval_reg;
         tcpwm_pkg::TCPWM_CMP_GT:   cmp_true = count_reg >  cmpval_reg;
         default:                   cmp_true = 1'b0;
      endcase
   end

   wire cmp_live = cmp_true & ~kill_s & (state_reg != tcpwm_pkg::TCPWM_ST_IDLE);
   logic cmp_prev_reg;

   // outputs: compare, terminal count or the compare complement
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_out      <= 1'b0;
         tc_out       <= 1'b0;
         cmp_prev_reg <= 1'b0;
      end else begin
         cmp_out      <= cmp_live;
         cmp_prev_reg <= cmp_true;
         if (ctrl_reg[`TCPWM_CTRL_TCSEL]) begin
            tc_out <= ~cmp_true & ~kill_s & (state_reg != tcpwm_pkg::TCPWM_ST_IDLE);
         end else begin
            tc_out <= tc_evt;
         end
      end
   end

   // pwm pair with deadband, killed to both low
   logic dead_true;
   logic dead_comp;

   tcpwm_dead u_dead (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .cmp_in      (cmp_live),
      .dead_cycles (dead_reg),
      .pwm_true    (dead_true),
      .pwm_comp    (dead_comp)
   );

   // kill holds both pwm outputs low, not just the true side
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_true_out <= 1'b0;
         pwm_comp_out <= 1'b0;
      end else begin
         pwm_true_out <= dead_true & ~kill_s;
         pwm_comp_out <= dead_comp & ~kill_s;
      end
   end

   // ----------------------------------------
   // sticky status, mask, interrupt
   // ----------------------------------------
   wire [2:0] evt = {cap_evt, cmp_true & ~cmp_prev_reg, tc_evt};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_reg <= 3'h0;
         irq      <= 1'b0;
      end else begin
         stat_reg <= (stat_reg & ~(wr_stat ? hwdata[2:0] : 3'h0)) | evt;
         irq      <= |(stat_reg & mask_reg);
      end
   end

   AST_TC_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
      (tc_out && !ctrl_reg[`TCPWM_CTRL_TCSEL]) |=> !tc_out)
      else $error("terminal count pulse too long");
   AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
      (tc_evt && !rst_evt && run_bit) |=> count_reg == $past(period_reg))
      else $error("no reload at terminal count");
   AST_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
      (step && !at_zero && !rst_evt && run_bit) |=> count_reg == $past(count_reg) - 16'h0001)
      else $error("counter did not decrement");
   AST_KILL: assert property (@(posedge hclk) disable iff (!hresetn)
      kill_s |=> !cmp_out) else $error("kill did not force output");
   AST_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      (mode == tcpwm_pkg::TCPWM_GATED && !en_s && !rst_evt && !start) |=> $stable(count_reg))
      else $error("gated counter moved");
   AST_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
      (tc_evt && mode == tcpwm_pkg::TCPWM_ONCE && run_bit && !rst_evt)
      |=> state_reg == tcpwm_pkg::TCPWM_ST_DONE) else $error("one shot kept running");
   AST_CAPT: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_evt |=> capt_reg == $past(count_reg)) else $error("capture missed");
   AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
      tc_evt |=> ##1 (stat_reg[`TCPWM_ST_TC] || $past(wr_stat)))
      else $error("tc status not set");
endmodule : tcpwm_top

/* File: verilog/tcpwm_map.svh */
// Purpose: register map, field positions and reset values of the timer/counter/pwm block
// Assumes: ahb-lite word registers, 32-bit data
// Notes:   included by the top-level design and the bench
`ifndef TCPWM_MAP_SVH
`define TCPWM_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TCPWM_OFS_CTRL    8'h00
`define TCPWM_OFS_PERIOD  8'h04
`define TCPWM_OFS_CMP     8'h08
`define TCPWM_OFS_COUNT   8'h0c
`define TCPWM_OFS_CAPT    8'h10
`define TCPWM_OFS_DEAD    8'h14
`define TCPWM_OFS_STAT    8'h18
`define TCPWM_OFS_MASK    8'h1c
`define TCPWM_OFS_CLKDIV  8'h20

// ----------------------------------------
// control fields
// ----------------------------------------
`define TCPWM_CTRL_RUN    0
`define TCPWM_CTRL_MODE_LO 1
`define TCPWM_CTRL_MODE_HI 2
`define TCPWM_CTRL_CMP_LO 3
`define TCPWM_CTRL_CMP_HI 5
`define TCPWM_CTRL_TCSEL  6
`define TCPWM_CTRL_CLKSEL 7

// ----------------------------------------
// status bits
// ----------------------------------------
`define TCPWM_ST_TC       0
`define TCPWM_ST_CMP      1
`define TCPWM_ST_CAPT     2

// ----------------------------------------
// reset values
// ----------------------------------------
`define TCPWM_RST_CTRL    8'h00
`define TCPWM_RST_PERIOD  16'hffff
`define TCPWM_RST_CMP     16'h8000
`define TCPWM_RST_DEAD    8'h00
`define TCPWM_RST_CLKDIV  16'h0000

`endif

/* File: verilog/tcpwm_pkg.sv */
// Purpose: types of the timer/counter/pwm block
// Assumes: nothing
// Notes:   used as tcpwm_pkg::name
package tcpwm_pkg;
   typedef enum logic [1:0] {
      TCPWM_FREE   = 2'h0,
      TCPWM_ONCE   = 2'h1,
      TCPWM_GATED  = 2'h2
   } tcpwm_mode_t;

   typedef enum logic [2:0] {
      TCPWM_CMP_LESS = 3'h0,  // cmp_less
      TCPWM_CMP_LE   = 3'h1,  // cmp_less_or_equal
      TCPWM_CMP_EQ   = 3'h2,  // cmp_equal
      TCPWM_CMP_GE   = 3'h3,  // cmp_greater_or_equal
      TCPWM_CMP_GT   = 3'h4   // cmp_greater
   } tcpwm_cmp_t;

   typedef enum logic [2:0] {
      TCPWM_ST_IDLE = 3'h1,
      TCPWM_ST_RUN  = 3'h2,
      TCPWM_ST_DONE = 3'h4
   } tcpwm_state_t;
endpackage : tcpwm_pkg

/* File: verilog/tcpwm_dead.sv */
// Purpose: deadband generator for one complementary pwm pair
// Assumes: cmp_in from logic on hclk
// Notes:   each output rises only after its delay has elapsed
`timescale 1ns/1ps
module tcpwm_dead (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       cmp_in,
   input  wire logic [7:0] dead_cycles,
   output logic            pwm_true,
   output logic            pwm_comp
);
   logic [7:0] dly_reg;
   logic       last_reg;

   // ----------------------------------------
   // delay counter restarts on each edge of the compare
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dly_reg  <= 8'h00;
         last_reg <= 1'b0;
         pwm_true <= 1'b0;
         pwm_comp <= 1'b0;
      end else begin
         last_reg <= cmp_in;
         if (cmp_in != last_reg) begin
            dly_reg  <= dead_cycles;
            pwm_true <= 1'b0;
            pwm_comp <= 1'b0;
         end else if (dly_reg != 8'h00) begin
            dly_reg <= dly_reg - 8'h01;
         end else begin
            pwm_true <= cmp_in;
            pwm_comp <= ~cmp_in;
         end
      end
   end

   AST_DEAD_EXCL: assert property (@(posedge hclk) disable iff (!hresetn)
      !(pwm_true && pwm_comp)) else $error("pwm pair active together");
endmodule : tcpwm_dead

/* File: dv/tcpwm_route_model.sv */
// Purpose: routing logic that drives the timer control inputs
// Assumes: tasks are called from the bench, hclk is the system clock
// Notes:   reset and capture pulses are held for four hclk cycles, external clock pulses for three, to pass the synchronisers
`timescale 1ns/1ps
module tcpwm_route_model (
   input  wire logic hclk,
   output logic      tmr_reset_in,
   output logic      capture_in,
   output logic      enable_in,
   output logic      kill_in,
   output logic      ext_clk_in
);
   // -------------------------------
   // idle levels
   // -------------------------------
   initial begin
      tmr_reset_in = 1'b0;
      capture_in   = 1'b0;
      enable_in    = 1'b0;
      kill_in      = 1'b0;
      ext_clk_in   = 1'b0;
   end

   // -------------------------------
   // stimulus tasks
   // -------------------------------
   // restart or capture request, held long enough to be seen
   task automatic pulse(input int which);
      @(posedge hclk);
      if (which == 0) tmr_reset_in <= 1'b1;
      else capture_in <= 1'b1;
      repeat (4) @(posedge hclk);
      tmr_reset_in <= 1'b0;
      capture_in   <= 1'b0;
   endtask : pulse

   // external count clock, stands still outside bursts
   task automatic ext_ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         ext_clk_in <= 1'b1;
         repeat (3) @(posedge hclk);
         ext_clk_in <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask : ext_ticks
endmodule : tcpwm_route_model

/* File: dv/tb_top.sv */
// Purpose: self-checking bench of the timer/counter/pwm block
// Assumes: single ahb-lite slave, zero wait answers still polled
// Notes:   counts over windows tolerate a few cycles of sync delay
`timescale 1ns/1ps
`include "tcpwm_map.svh"
module tb_top;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, a, b, c, d;
   logic [1:0]  htrans;
   logic        cmp_out, tc_out, pwm_true_out, pwm_comp_out, irq, tc_prev;
   logic        tmr_reset_in, capture_in, enable_in, kill_in, ext_clk_in;
   int          errors, checks, hi_cnt, tc_cnt, tc_dbl, both_lo, pwm_hi, overlap;
   int          s0, s1, s2;
   int          exp_hi [5] = '{40, 50, 10, 60, 50};

   tcpwm_top u_tcpwm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tmr_reset_in(tmr_reset_in), .capture_in(capture_in), .enable_in(enable_in),
      .kill_in(kill_in), .ext_clk_in(ext_clk_in), .cmp_out(cmp_out), .tc_out(tc_out),
      .pwm_true_out(pwm_true_out), .pwm_comp_out(pwm_comp_out), .irq(irq));
   tcpwm_route_model u_tcpwm_route_model (.hclk(hclk), .tmr_reset_in(tmr_reset_in),
      .capture_in(capture_in), .enable_in(enable_in), .kill_in(kill_in),
      .ext_clk_in(ext_clk_in));

   // -------------------------------
   // clock, reset, watchdog
   // -------------------------------
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      #400000;
      errors++;
      finish_test();
   end

   // output monitors, sampled mid-cycle where outputs are settled
   always @(negedge hclk) begin
      hi_cnt  += (cmp_out === 1'b1);
      tc_cnt  += (tc_out === 1'b1);
      tc_dbl  += (tc_out === 1'b1 && tc_prev === 1'b1);
      pwm_hi  += (pwm_true_out === 1'b1) + (pwm_comp_out === 1'b1);
      both_lo += (pwm_true_out === 1'b0 && pwm_comp_out === 1'b0);
      overlap += (pwm_true_out !== 1'b0 && pwm_comp_out !== 1'b0);
      tc_prev = tc_out;
   end

   // -------------------------------
   // tasks
   // -------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   // one single word transfer, waits for hready in both phases
   task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
      haddr  <= {24'h000000, ad};
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic [31:0] x;
      bus(ad, 1'b1, wd, x);
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] x);
      bus(ad, 1'b0, 32'h00000000, x);
   endtask : rd

   // restart with a fresh period load
   task automatic start(input logic [31:0] ctl);
      wr(`TCPWM_OFS_CTRL, 32'h00000000);
      wr(`TCPWM_OFS_CTRL, ctl);
   endtask : start

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // -------------------------------
   // test sequence
   // -------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = '0; hwdata = '0;
      idle(3);
      hresetn <= 1'b1;
      idle(1);
      // reset values and an unmapped word
      rd(`TCPWM_OFS_CTRL, a);   chk("ctrl", 32'h00000000, a);
      rd(`TCPWM_OFS_PERIOD, a); chk("period", 32'h0000ffff, a);
      rd(`TCPWM_OFS_CMP, a);    chk("cmp", 32'h00008000, a);
      rd(`TCPWM_OFS_DEAD, a);   chk("dead", 32'h00000000, a);
      rd(`TCPWM_OFS_CLKDIV, a); chk("clkdiv", 32'h00000000, a);
      rd(8'h40, a);             chk("unmapped", 32'h00000000, a);
      chk("hresp", 32'h00000000, {31'h0, hresp});
      // free run, live reads, timer reset reload
      wr(`TCPWM_OFS_PERIOD, 32'd200);
      start(32'h00000001);
      idle(50);
      rd(`TCPWM_OFS_COUNT, a);
      rd(`TCPWM_OFS_COUNT, b);
      chk("count_down", 1, b < a && a <= 200);
      idle(100);
      rd(`TCPWM_OFS_COUNT, c);
      u_tcpwm_route_model.pulse(0);
      idle(2);
      rd(`TCPWM_OFS_COUNT, d);
      chk("reset_reload", 1, c < 120 && d >= 185 && d <= 200);
      // terminal count pulses, period 9 gives ten per hundred cycles
      wr(`TCPWM_OFS_PERIOD, 32'd9);
      wr(`TCPWM_OFS_CMP, 32'd4);
      start(32'h00000001);
      idle(10);
      s0 = tc_cnt; s1 = tc_dbl;
      idle(100);
      chk("tc_count", 1, tc_cnt - s0 >= 9 && tc_cnt - s0 <= 11);
      chk("tc_width", 0, tc_dbl - s1);
      // every compare mode, high time over ten periods
      for (int m = 0; m < 5; m++) begin
         start(32'h00000001 | (m << 3));
         idle(10);
         s0 = hi_cnt;
         idle(100);
         s1 = hi_cnt - s0 - exp_hi[m];
         chk("cmp_mode", 1, s1 >= -3 && s1 <= 3);
      end
      // kill forces compare outputs and pwm low
      u_tcpwm_route_model.kill_in <= 1'b1;
      start(32'h00000019);
      idle(6);
      s0 = hi_cnt; s1 = pwm_hi;
      idle(30);
      chk("kill_cmp", 0, hi_cnt - s0);
      chk("kill_pwm", 0, pwm_hi - s1);
      u_tcpwm_route_model.kill_in <= 1'b0;
      // deadband between complementary outputs
      wr(`TCPWM_OFS_PERIOD, 32'd49);
      wr(`TCPWM_OFS_CMP, 32'd20);
      wr(`TCPWM_OFS_DEAD, 32'd5);
      start(32'h00000019);
      idle(60);
      s0 = both_lo; s1 = pwm_hi; s2 = overlap;
      idle(200);
      chk("dead_gap", 1, both_lo - s0 >= 40);
      chk("pwm_active", 1, pwm_hi - s1 >= 100);
      chk("pwm_overlap", 0, overlap - s2);
      // one shot stops, terminal count status and interrupt
      wr(`TCPWM_OFS_PERIOD, 32'd9);
      start(32'h00000003);
      wr(`TCPWM_OFS_STAT, 32'h00000007);
      idle(40);
      rd(`TCPWM_OFS_COUNT, a);
      idle(10);
      rd(`TCPWM_OFS_COUNT, b);
      chk("oneshot_stop", a, b);
      rd(`TCPWM_OFS_STAT, c);
      chk("stat_tc", 1, c[`TCPWM_ST_TC]);
      wr(`TCPWM_OFS_MASK, 32'h00000001);
      idle(3);
      chk("irq_raised", 1, irq);
      wr(`TCPWM_OFS_MASK, 32'h00000000);
      idle(3);
      chk("irq_masked", 0, irq);
      wr(`TCPWM_OFS_MASK, 32'h00000001);
      wr(`TCPWM_OFS_STAT, 32'h00000007);
      idle(3);
      chk("irq_cleared", 0, irq);
      // gated mode with complement compare on the tc pin
      start(32'h0000005d);
      idle(10);
      rd(`TCPWM_OFS_COUNT, a);
      idle(20);
      rd(`TCPWM_OFS_COUNT, b);
      chk("gated_hold", a, b);
      chk("tc_complement", {31'h0, ~cmp_out}, {31'h0, tc_out});
      u_tcpwm_route_model.enable_in <= 1'b1;
      idle(20);
      rd(`TCPWM_OFS_COUNT, c);
      chk("gated_run", 1, c !== b);
      u_tcpwm_route_model.enable_in <= 1'b0;
      // capture of the running count
      wr(`TCPWM_OFS_PERIOD, 32'd200);
      start(32'h00000001);
      idle(60);
      u_tcpwm_route_model.pulse(1);
      idle(4);
      rd(`TCPWM_OFS_COUNT, d);
      rd(`TCPWM_OFS_CAPT, c);
      chk("capture", 1, c > d && c - d < 20 && c <= 200);
      rd(`TCPWM_OFS_STAT, a);
      chk("stat_capt", 1, a[`TCPWM_ST_CAPT]);
      // external count clock, still when stopped, ten edges count ten
      start(32'h00000081);
      idle(10);
      rd(`TCPWM_OFS_COUNT, a);
      idle(20);
      rd(`TCPWM_OFS_COUNT, b);
      chk("ext_still", a, b);
      u_tcpwm_route_model.ext_ticks(10);
      idle(6);
      rd(`TCPWM_OFS_COUNT, c);
      chk("ext_ticks", 32'd10, b - c);
      // divided tick: a divider of one halves the count rate
      wr(`TCPWM_OFS_CLKDIV, 32'd1);
      start(32'h00000001);
      idle(10);
      rd(`TCPWM_OFS_COUNT, a);
      idle(40);
      rd(`TCPWM_OFS_COUNT, b);
      chk("div_ticks", 32'd21, a - b);
      finish_test();
   end
endmodule : tb_top
